// >>> common/dac_link_pkg.sv
// Constants, types and helpers shared by both ends of the serial link
// Assumes both ends run from a 10 MHz aclk
package dac_link_pkg;
    localparam int CLK_NS = 100;
    localparam int FRAME_BITS = 24;
    localparam int RW_BIT = 23;
    localparam int ADDR_LSB = 16;
    localparam int BOOT_TIME_NS = 3000;
    localparam int BOOT_CYC = (BOOT_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_TIME_US = 550;
    localparam int WAKE_CYC = (WAKE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int LINK_LAT = 8;
    localparam int SCLK_HALF = 16;
    // Device register addresses
    localparam logic [6:0] ADDR_CONFIG = 7'h1f;
    localparam logic [6:0] ADDR_TRIGGER = 7'h1c;
    localparam logic [6:0] ADDR_STATUS = 7'h22;
    localparam logic [6:0] ADDR_GPIO = 7'h24;
    localparam logic [6:0] ADDR_LINK = 7'h26;
    // Field positions
    localparam int LOCK_BIT = 14;
    localparam int CH_STRIDE = 3;
    localparam int RESET_KEY_LSB = 0;
    localparam int UNLOCK_LSB = 4;
    localparam int PROG_BIT = 8;
    localparam int SERIAL_OUT_ENABLE_BIT = 0;
    localparam int EDGE_BIT = 1;
    localparam int RST_EN_BIT = 0;
    localparam int DSLEEP_BIT = 1;
    localparam int SLEEP_MAP_LSB = 4;
    localparam int ALARM_USER_BIT = 0;
    localparam int ALARM_INT_BIT = 1;
    localparam logic [3:0] RESET_KEY = 4'ha;
    localparam logic [3:0] UNLOCK_KEY = 4'h5;
    localparam logic [1:0] VOUT_HIZ = 2'h3;
    // Factory values
    localparam logic [15:0] CONFIG_RST = 16'h0fff;
    localparam logic [15:0] LINK_RST = 16'h0000;
    localparam logic [15:0] GPIO_RST = 16'h0000;
    localparam logic [15:0] INT_WORD0 = 16'h5a3c;
    localparam logic [15:0] INT_WORD1 = 16'hc3a5;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    // Host register offsets and answers
    localparam logic [3:0] H_CMD = 4'h0;
    localparam logic [3:0] H_STATUS = 4'h4;
    localparam logic [3:0] H_RX = 4'h8;
    localparam logic [3:0] H_CTRL = 4'hc;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] CTRL_RST = 2'h1;

    typedef enum logic [4:0] {
        ST_BOOT = 5'b00001,
        ST_RUN = 5'b00010,
        ST_HOLD = 5'b00100,
        ST_SLEEP = 5'b01000,
        ST_WAKE = 5'b10000
    } dev_state_t;

    typedef enum logic [2:0] {
        HS_WAIT = 3'b001,
        HS_IDLE = 3'b010,
        HS_SHIFT = 3'b100
    } host_state_t;

    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [15:0] word);
        logic [15:0] c;
        c = crc;
        for (int i = 15; i >= 0; i--) begin
            c = (c[15] ^ word[i]) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
        end
        return c;
    endfunction

    function automatic logic [15:0] crc3(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        return crc_step(crc_step(crc_step(CRC_INIT, a), b), c);
    endfunction

    localparam logic [15:0] FACTORY_CRC = crc3(CONFIG_RST, LINK_RST, GPIO_RST);
    localparam logic [15:0] INT_CRC = crc3(INT_WORD0, INT_WORD1, 16'h0000);
endpackage

// >>> common/dac_link_if.sv
// Pins between the converter's serial port and its host controller
// Assumes a pull-up on the data-out wire while the device releases it
`timescale 1ns/1ps
interface dac_link_if;
    logic sclk;
    logic sync_n;
    logic sdi;
    logic sdo;
    logic sdo_oe_n;
    logic gpio;
    logic sdo_line;

    assign sdo_line = sdo_oe_n ? 1'b1 : sdo;

    modport device (input sclk, input sync_n, input sdi, input gpio, output sdo, output sdo_oe_n);
    modport host (output sclk, output sync_n, output sdi, output gpio, input sdo_line);
endinterface

// >>> src/dac_spi_device.sv
// Control core of the quad converter: serial port, resets, lock, store check
// Assumes link pins are asynchronous to aclk and sclk is far slower than aclk
`timescale 1ns/1ps

module dac_spi_device
    import dac_link_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC,
    parameter logic [15:0] INT_CRC_STORED = INT_CRC
) (
    input wire logic aclk,
    input wire logic aresetn,
    dac_link_if.device link,
    output logic [7:0] vout_state,
    output logic [3:0] iout_on,
    output logic ready,
    output logic deep_sleep,
    output logic iface_fixed
);
    // ******************************
    // Pin synchronisers
    // ******************************
    wire [3:0] pin_raw;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] pin_f;
    logic [3:0] pin_q;

    assign pin_raw = {link.gpio, link.sdi, link.sync_n, link.sclk};

    for (genvar g = 0; g < 4; g++) begin : g_sync
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                s1[g] <= 1'b1;
                s2[g] <= 1'b1;
                s3[g] <= 1'b1;
                pin_f[g] <= 1'b1;
                pin_q[g] <= 1'b1;
            end else begin
                s1[g] <= pin_raw[g];
                s2[g] <= s1[g];
                s3[g] <= s2[g];
                if (s2[g] == s3[g]) begin
                    pin_f[g] <= s3[g];
                end
                pin_q[g] <= pin_f[g];
            end
        end
    end

    wire sclk_fall = pin_q[0] && !pin_f[0];
    wire sclk_rise = !pin_q[0] && pin_f[0];
    wire sync_low = !pin_f[1];
    wire sync_fall = pin_q[1] && !pin_f[1];
    wire sync_rise = !pin_q[1] && pin_f[1];
    wire sdi_v = pin_f[2];
    wire gpio_v = pin_f[3];
    wire gpio_fall = pin_q[3] && !pin_f[3];
    wire gpio_rise = !pin_q[3] && pin_f[3];

    // ******************************
    // Registers and store
    // ******************************
    dev_state_t state;
    logic [15:0] cnt;
    logic [15:0] cfg;
    logic [15:0] hl;
    logic [15:0] gcfg;
    logic alarm_user;
    logic alarm_int;
    logic [15:0] nv [0:2];
    logic [15:0] nv_crc;
    logic [23:0] rx_sh;
    logic [23:0] tx_sh;
    logic [23:0] echo;
    logic [4:0] bit_cnt;
    logic [4:0] tx_cnt;

    wire active = (state == ST_RUN);
    wire frame_ok = active && sync_rise && bit_cnt == 5'(FRAME_BITS);
    wire f_rw = rx_sh[RW_BIT];
    wire [6:0] f_addr = rx_sh[RW_BIT-1:ADDR_LSB];
    wire [15:0] f_data = rx_sh[15:0];
    wire wr = frame_ok && !f_rw;
    wire wr_trig = wr && f_addr == ADDR_TRIGGER;
    wire soft_rst = wr_trig && f_data[RESET_KEY_LSB+:4] == RESET_KEY;
    wire unlock = wr_trig && f_data[UNLOCK_LSB+:4] == UNLOCK_KEY;
    wire prog = wr_trig && f_data[PROG_BIT];
    wire wr_ok = wr && !cfg[LOCK_BIT];
    wire rst_pin_low = gcfg[RST_EN_BIT] && !gpio_v;
    wire sleep_entry = gcfg[DSLEEP_BIT] && !gcfg[RST_EN_BIT] && gpio_fall;
    wire boot_start = (active && soft_rst) || (state == ST_HOLD && gpio_rise);
    wire boot_done = state == ST_BOOT && cnt == 16'(BOOT_CYC - 1);
    wire user_bad = crc3(nv[0], nv[1], nv[2]) != nv_crc;
    wire int_bad = INT_CRC != INT_CRC_STORED;
    wire use_factory = user_bad || int_bad;
    wire [15:0] status_v = {14'h0000, alarm_int, alarm_user};
    wire [15:0] rd_val = f_addr == ADDR_CONFIG ? cfg :
                         f_addr == ADDR_LINK ? hl :
                         f_addr == ADDR_GPIO ? gcfg :
                         f_addr == ADDR_STATUS ? status_v : 16'h0000;

    // ******************************
    // Reset, boot and sleep sequencing
    // ******************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_BOOT;
            cnt <= 16'h0000;
        end else begin
            unique case (state)
                ST_BOOT: begin
                    cnt <= boot_done ? 16'h0000 : cnt + 16'h0001;
                    if (boot_done) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    cnt <= 16'h0000;
                    if (soft_rst) begin
                        state <= ST_BOOT;
                    end else if (rst_pin_low) begin
                        state <= ST_HOLD;
                    end else if (sleep_entry) begin
                        state <= ST_SLEEP;
                    end
                end
                ST_HOLD: begin
                    if (gpio_rise) begin
                        state <= ST_BOOT;
                    end
                end
                ST_SLEEP: begin
                    if (gpio_rise) begin
                        state <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(WAKE_CYCLES - 1)) begin
                        state <= ST_RUN;
                        cnt <= 16'h0000;
                    end
                end
            endcase
        end
    end

    // Store contents survive soft resets; factory data returns only on power loss or on a boot that finds a bad CRC
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= CONFIG_RST;
            hl <= LINK_RST;
            gcfg <= GPIO_RST;
            alarm_user <= 1'b0;
            alarm_int <= 1'b0;
            nv[0] <= CONFIG_RST;
            nv[1] <= LINK_RST;
            nv[2] <= GPIO_RST;
            nv_crc <= FACTORY_CRC;
        end else if (boot_start) begin
            alarm_user <= 1'b0;
            alarm_int <= 1'b0;
        end else if (boot_done) begin
            cfg <= use_factory ? CONFIG_RST : nv[0];
            hl <= use_factory ? LINK_RST : nv[1];
            gcfg <= use_factory ? GPIO_RST : nv[2];
            alarm_user <= user_bad;
            alarm_int <= int_bad;
        end else if (active) begin
            if (wr_ok && f_addr == ADDR_CONFIG) begin
                cfg <= f_data;
            end else if (unlock) begin
                cfg[LOCK_BIT] <= 1'b0;
            end
            if (wr_ok && f_addr == ADDR_LINK) begin
                hl <= f_data;
            end
            if (wr_ok && f_addr == ADDR_GPIO) begin
                gcfg <= f_data;
            end
            if (prog) begin
                nv[0] <= cfg;
                nv[1] <= hl;
                nv[2] <= gcfg;
                nv_crc <= crc3(cfg, hl, gcfg);
            end
        end
    end

    // ******************************
    // Serial frame engine
    // ******************************
    // In falling-edge mode the first falling edge keeps bit 23 on the wire
    wire tx_edge = hl[EDGE_BIT] ? (sclk_fall && bit_cnt != 5'd0) : sclk_rise;
    wire tx_shift = active && sync_low && tx_edge && tx_cnt < 5'(FRAME_BITS - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_sh <= 24'h00_0000;
            tx_sh <= 24'h00_0000;
            echo <= 24'h00_0000;
            bit_cnt <= 5'd0;
            tx_cnt <= 5'd0;
            iface_fixed <= 1'b0;
        end else begin
            if (sync_fall) begin
                bit_cnt <= 5'd0;
                tx_cnt <= 5'd0;
                tx_sh <= echo;
            end else begin
                if (active && sync_low && sclk_fall && bit_cnt < 5'(FRAME_BITS)) begin
                    rx_sh <= {rx_sh[22:0], sdi_v};
                    bit_cnt <= bit_cnt + 5'd1;
                end
                if (tx_shift) begin
                    tx_sh <= {tx_sh[22:0], 1'b0};
                    tx_cnt <= tx_cnt + 5'd1;
                end
            end
            if (frame_ok) begin
                echo <= {f_rw, f_addr, rd_val};
                iface_fixed <= 1'b1;
            end
        end
    end

    assign link.sdo = tx_sh[RW_BIT];

    // ******************************
    // Output and channel state
    // ******************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.sdo_oe_n <= 1'b1;
            ready <= 1'b0;
            deep_sleep <= 1'b0;
        end else begin
            link.sdo_oe_n <= !hl[SERIAL_OUT_ENABLE_BIT];
            ready <= active;
            deep_sleep <= state == ST_SLEEP || state == ST_WAKE;
        end
    end

    for (genvar c = 0; c < 4; c++) begin : g_ch
        wire pd = (gcfg[SLEEP_MAP_LSB+c] && !gcfg[RST_EN_BIT] && !gpio_v) || !active;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                vout_state[2*c+:2] <= VOUT_HIZ;
                iout_on[c] <= 1'b0;
            end else begin
                vout_state[2*c+:2] <= pd ? VOUT_HIZ : cfg[CH_STRIDE*c+:2];
                iout_on[c] <= !pd && !cfg[CH_STRIDE*c+2];
            end
        end
    end
endmodule

// >>> src/spi_host_ctrl.sv
// Host end: AXI4-Lite command registers driving the converter's serial port
// Assumes aclk at 10 MHz; the bus master keeps one write and one read open
`timescale 1ns/1ps
module spi_host_ctrl
    import dac_link_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    dac_link_if.host link
);
    // ******************************
    // AXI4-Lite slave
    // ******************************
    host_state_t state;
    logic aw_got;
    logic w_got;
    logic [31:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic [1:0] ctrl;
    logic [23:0] rx;
    logic [23:0] sh;
    logic [15:0] wait_left;
    logic [4:0] div;
    logic [5:0] edges;

    wire busy = state != HS_IDLE;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire do_wr = aw_got && w_got && !s_axi_bvalid;
    wire aw_map = aw_a[31:4] == 28'h000_0000;
    wire cmd_wr = do_wr && aw_map && aw_a[3:0] == H_CMD && w_s[2:0] == 3'b111 && !busy;
    wire ctrl_wr = do_wr && aw_map && aw_a[3:0] == H_CTRL && w_s[0] && !busy;
    wire next_aw_got = aw_hs || (aw_got && !do_wr);
    wire next_w_got = w_hs || (w_got && !do_wr);
    wire next_bvalid = do_wr || (s_axi_bvalid && !s_axi_bready);
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire next_rvalid = ar_hs || (s_axi_rvalid && !s_axi_rready);
    wire ar_map = s_axi_araddr[31:4] == 28'h000_0000;
    wire [31:0] rd_mux = s_axi_araddr[3:0] == H_STATUS ? {30'h0000_0000, state == HS_WAIT, busy} :
                         s_axi_araddr[3:0] == H_RX ? {8'h00, rx} :
                         s_axi_araddr[3:0] == H_CTRL ? {30'h0000_0000, ctrl} : 32'h0000_0000;
    // A reset-key write to the trigger register restarts the device's boot
    wire is_reset_cmd = w_d[RW_BIT:ADDR_LSB] == {1'b0, ADDR_TRIGGER} && w_d[RESET_KEY_LSB+:4] == RESET_KEY;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_a <= 32'h0000_0000;
            w_d <= 32'h0000_0000;
            w_s <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            if (aw_hs) begin
                aw_a <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_d <= s_axi_wdata;
                w_s <= s_axi_wstrb;
            end
            s_axi_awready <= !next_aw_got && !next_bvalid;
            s_axi_wready <= !next_w_got && !next_bvalid;
            s_axi_bvalid <= next_bvalid;
            if (do_wr) begin
                s_axi_bresp <= (cmd_wr || ctrl_wr) ? RESP_OKAY : RESP_SLVERR;
            end
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_hs) begin
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= ar_map ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ******************************
    // Serial master
    // ******************************
    logic s1;
    logic s2;
    logic s3;
    logic sdo_f;
    wire half_end = div == 5'(SCLK_HALF - 1);
    wire toggle = state == HS_SHIFT && half_end && edges < 6'(2 * FRAME_BITS);
    wire going_up = toggle && !link.sclk;
    wire going_down = toggle && link.sclk;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            sdo_f <= 1'b1;
        end else begin
            s1 <= link.sdo_line;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                sdo_f <= s3;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= HS_WAIT;
            wait_left <= 16'(BOOT_CYC - 1);
            ctrl <= CTRL_RST;
            rx <= 24'h00_0000;
            sh <= 24'h00_0000;
            div <= 5'd0;
            edges <= 6'd0;
            link.sclk <= 1'b1;
            link.sync_n <= 1'b1;
            link.sdi <= 1'b0;
            link.gpio <= 1'b1;
        end else begin
            link.gpio <= ctrl[0];
            unique case (state)
                HS_WAIT: begin
                    wait_left <= wait_left - 16'h0001;
                    if (wait_left == 16'h0000) begin
                        state <= HS_IDLE;
                    end
                end
                HS_IDLE: begin
                    if (cmd_wr) begin
                        state <= HS_SHIFT;
                        sh <= {w_d[22:0], 1'b0};
                        link.sdi <= w_d[RW_BIT];
                        link.sync_n <= 1'b0;
                        div <= 5'd0;
                        edges <= 6'd0;
                    end else if (ctrl_wr) begin
                        ctrl <= w_d[1:0];
                        if (w_d[0] != ctrl[0]) begin
                            state <= HS_WAIT;
                            wait_left <= 16'(WAKE_CYCLES + LINK_LAT - 1);
                        end
                    end
                end
                HS_SHIFT: begin
                    div <= half_end ? 5'd0 : div + 5'd1;
                    if (half_end) begin
                        edges <= edges + 6'd1;
                    end
                    if (toggle) begin
                        link.sclk <= !link.sclk;
                    end
                    if (going_up) begin
                        link.sdi <= sh[RW_BIT];
                        sh <= {sh[22:0], 1'b0};
                    end
                    // Sample opposite to the device's launch edge
                    if ((going_up && ctrl[1]) || (going_down && !ctrl[1])) begin
                        rx <= {rx[22:0], sdo_f};
                    end
                    if (half_end && edges == 6'(2 * FRAME_BITS)) begin
                        link.sync_n <= 1'b1;
                    end
                    if (half_end && edges == 6'(2 * FRAME_BITS + 1)) begin
                        state <= is_reset_cmd ? HS_WAIT : HS_IDLE;
                        wait_left <= 16'(BOOT_CYC + LINK_LAT - 1);
                    end
                end
            endcase
        end
    end
endmodule

// >>> sim/dac_link_monitor.sv
// Checker on the serial link wires between host end and converter core
// Assumes both ends share aclk and are joined by one link interface
`timescale 1ns/1ps
module dac_link_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    // ****************************************
    // Frame shape and output hold
    // ****************************************
    logic [5:0] falls;
    always_ff @(posedge aclk) begin
        if (!aresetn || sync_n) begin
            falls <= 6'h00;
        end else if ($fell(sclk)) begin
            falls <= falls + 6'h01;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    idle_high_a: assert property (sync_n |-> sclk) else $error("sclk moved outside frame");
    frame_len_a: assert property ($rose(sync_n) |-> falls == 6'h18) else $error("frame not 24 falls");
    lead_in_a: assert property ($fell(sync_n) |-> (sclk && !sync_n) [*8]) else $error("short lead-in");
    half_per_a: assert property (!sync_n && $changed(sclk) |=> $stable(sclk) [*8])
        else $error("sclk half period short");
    sdi_edge_a: assert property (!sync_n && $changed(sdi) |-> $rose(sclk) || $fell(sync_n))
        else $error("sdi moved off edge");
    frame_tail_a: assert property ($rose(sync_n) |-> $past(sclk) && $stable(sclk))
        else $error("frame closed with sclk low");
    sdo_hold_a: assert property (sync_n && $past(sync_n) && !sdo_oe_n && !$past(sdo_oe_n) |-> $stable(sdo))
        else $error("sdo moved between frames");
    sdo_quiet_a: assert property ((!sync_n && $stable(sclk)) [*8] |-> $stable(sdo))
        else $error("sdo moved without sclk edge");
endmodule

// >>> sim/dac_spi_reset_control_tb.sv
// Testbench: AXI host end drives the converter core over the serial link
// Assumes 10 MHz aclk and a shortened wake count
`timescale 1ns/1ps
module dac_spi_reset_control_tb;
    import dac_link_pkg::*;
    // ****************************************
    // Harness
    // ****************************************
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, aw_r, w_r, bv, ar_r, rv, rdy, ds, fx;
    logic [31:0] awa = 0, wd = 0, ara = 0, rdat;
    logic [1:0] br, rr;
    logic [7:0] vs;
    logic [3:0] io;
    int err_count = 0, checks = 0, cyc = 0;
    dac_link_if lk();
    dac_spi_device #(.WAKE_CYCLES(20)) u_dac_spi_device (.aclk(aclk), .aresetn(aresetn), .link(lk.device),
        .vout_state(vs), .iout_on(io), .ready(rdy), .deep_sleep(ds), .iface_fixed(fx));
    spi_host_ctrl #(.WAKE_CYCLES(20)) u_spi_host_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(w_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(ar_r), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .link(lk.host));
    dac_link_monitor u_dac_link_monitor (.aclk(aclk), .aresetn(aresetn), .sclk(lk.sclk), .sync_n(lk.sync_n),
        .sdi(lk.sdi), .sdo(lk.sdo), .sdo_oe_n(lk.sdo_oe_n));
    initial forever #50 aclk = ~aclk;
    // Frames take ~850 cycles each; ceiling leaves double margin
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            close_out();
        end
    end
    task automatic close_out;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
        forever begin
            @(posedge aclk);
            if (aw_r && awv) awv <= 0;
            if (w_r && wv) wv <= 0;
            if (bv) break;
        end
        bre <= 0;
        `CHK("bresp", e, br)
    endtask
    task automatic rd(input logic [3:0] o, output logic [31:0] d);
        @(posedge aclk);
        ara <= {28'h000_0000, o}; arv <= 1; rre <= 1;
        forever begin
            @(posedge aclk);
            if (ar_r && arv) arv <= 0;
            if (rv) break;
        end
        rre <= 0;
        d = rdat;
        `CHK("rresp", RESP_OKAY, rr)
    endtask
    task automatic idle;
        logic [31:0] s;
        do rd(H_STATUS, s); while (s[1:0] !== 2'h0);
    endtask
    task automatic hw(input logic [3:0] o, input logic [31:0] d);
        wr({28'h000_0000, o}, d, RESP_OKAY);
        idle();
    endtask
    task automatic dw(input logic [6:0] a, input logic [15:0] d);
        hw(H_CMD, {8'h00, 1'h0, a, d});
    endtask
    task automatic dr(input logic [6:0] a, input logic [15:0] e);
        logic [31:0] s;
        hw(H_CMD, {8'h00, 1'h1, a, 16'h0000});
        hw(H_CMD, {8'h00, 1'h1, a, 16'h0000});
        rd(H_RX, s);
        `CHK("echo", {1'h1, a}, s[23:16])
        `CHK("data", e, s[15:0])
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_boot;
        idle();
        `CHK("vout", 8'hff, vs)
        `CHK("iout", 4'h0, io)
        `CHK("ready", 1'h1, rdy)
        wr(32'h0000_0040, 32'h0000_0000, RESP_SLVERR);
        dw(ADDR_LINK, 16'h0003);
        `CHK("fixed", 1'h1, fx)
        hw(H_CTRL, 32'h0000_0003);
        dr(ADDR_CONFIG, CONFIG_RST);
        dr(ADDR_STATUS, 16'h0000);
        dr(ADDR_LINK, 16'h0003);
    endtask
    task automatic t_pdn;
        dw(ADDR_CONFIG, 16'h07ac);
        `CHK("vout", 8'he4, vs)
        `CHK("iout", 4'h8, io)
        dr(ADDR_CONFIG, 16'h07ac);
    endtask
    task automatic t_lock;
        dw(ADDR_CONFIG, 16'h47ac);
        dw(ADDR_CONFIG, 16'h0fff);
        `CHK("locked", 8'he4, vs)
        dr(ADDR_CONFIG, 16'h47ac);
        dw(ADDR_TRIGGER, 16'h0050);
        dw(ADDR_CONFIG, 16'h0fff);
        `CHK("unlocked", 8'hff, vs)
    endtask
    task automatic t_soft;
        dw(ADDR_CONFIG, 16'h07ac);
        dw(ADDR_TRIGGER, 16'h000a);
        `CHK("soft", 8'hff, vs)
        `CHK("soft rdy", 1'h1, rdy)
        // Store the pattern, spoil the live copy, then reset to reload it
        dw(ADDR_CONFIG, 16'h07ac);
        dw(ADDR_TRIGGER, 16'h0100);
        dw(ADDR_CONFIG, 16'h0fff);
        dw(ADDR_TRIGGER, 16'h000a);
        `CHK("reload", 8'he4, vs)
        // Rising-edge launch, host samples on falling
        dw(ADDR_LINK, 16'h0001);
        hw(H_CTRL, 32'h0000_0001);
        dr(ADDR_STATUS, 16'h0000);
    endtask
    task automatic t_pin;
        dw(ADDR_GPIO, 16'h0001);
        hw(H_CTRL, 32'h0000_0002);
        `CHK("held", 1'h0, rdy)
        hw(H_CTRL, 32'h0000_0003);
        repeat (BOOT_CYC + 2) @(posedge aclk);
        `CHK("pin rdy", 1'h1, rdy)
    endtask
    task automatic t_sleep;
        dw(ADDR_GPIO, 16'h0010);
        hw(H_CTRL, 32'h0000_0002);
        `CHK("mapped", 8'he7, vs)
        hw(H_CTRL, 32'h0000_0003);
        `CHK("unmapped", 8'he4, vs)
        dw(ADDR_GPIO, 16'h0002);
        hw(H_CTRL, 32'h0000_0002);
        `CHK("sleep", 1'h1, ds)
        `CHK("sleep vout", 8'hff, vs)
        hw(H_CTRL, 32'h0000_0003);
        `CHK("awake", 1'h0, ds)
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        t_boot();
        t_pdn();
        t_lock();
        t_soft();
        t_pin();
        t_sleep();
        close_out();
    end
endmodule
